// ===== tb/ocsr_link_asserts.sv
`timescale 1ns/1ps
module ocsr_link_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic out_clock_reset_in,
    input wire logic extended_control_mode,
    input wire logic data_clock_phase_select,
    input wire logic demux_mode,
    input wire logic first_channel_out_clock,
    input wire logic second_channel_out_clock,
    input wire logic realigned_r
);
    logic seen_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // first enabled pulse is left unchecked, timing checked from the second on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_r <= 1'b0;
        end else if ($fell(out_clock_reset_in) && extended_control_mode) begin
            seen_r <= 1'b1;
        end
    end
    a_chan_in_phase: assert property (first_channel_out_clock == second_channel_out_clock)
        else $error("channel clocks differ");
    a_ecm_gate: assert property (realigned_r |-> extended_control_mode)
        else $error("realign outside extended mode");
    a_demux_held: assert property ((out_clock_reset_in && demux_mode && extended_control_mode)[*5]
        |-> ##2 first_channel_out_clock) else $error("demux clock not held high");
    a_sync_ninety: assert property ($fell(out_clock_reset_in) && data_clock_phase_select
        && extended_control_mode && seen_r |-> !realigned_r[*6] ##[1:6] realigned_r)
        else $error("90 degree realign timing");
    a_sync_zero: assert property ($fell(out_clock_reset_in) && !data_clock_phase_select
        && extended_control_mode && seen_r |-> !realigned_r[*7] ##[1:6] realigned_r)
        else $error("0 degree realign timing");
    a_pulse_width: assert property ($rose(out_clock_reset_in) |-> out_clock_reset_in[*7])
        else $error("reset pulse too short");
    a_pulse_gap: assert property ($fell(out_clock_reset_in) |-> !out_clock_reset_in[*8])
        else $error("pulses too close");
    a_phase_held: assert property (out_clock_reset_in |-> $stable(data_clock_phase_select))
        else $error("phase select moved in pulse");
    a_one_pulse: assert property (realigned_r |=> !realigned_r)
        else $error("realign strobe too long");
    a_demux_quarter: assert property (@(posedge hclk) disable iff (!hresetn || out_clock_reset_in)
        demux_mode && $past(demux_mode, 4) && $rose(first_channel_out_clock)
        |-> ##1 first_channel_out_clock ##1 !first_channel_out_clock) else $error("demux clock rate");
    c_ninety: cover property ($fell(out_clock_reset_in) && data_clock_phase_select);
    c_zero: cover property (realigned_r && !data_clock_phase_select);
    c_demux: cover property (realigned_r && demux_mode);
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, realigned_r, rd_dp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [63:0] q[$];
    int n_errors, checked, cyc, t_rel, n_re;
    int lat[2];
    ocsr_link_if u_ocsr_link_if ();
    ocsr_ctrl u_ocsr_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(u_ocsr_link_if.ctrl));
    ocsr_device u_ocsr_device (.hclk(hclk), .hresetn(hresetn), .link(u_ocsr_link_if.device),
        .realigned_r(realigned_r));
    ocsr_link_asserts u_ocsr_link_asserts (.hclk(hclk), .hresetn(hresetn),
        .out_clock_reset_in(u_ocsr_link_if.out_clock_reset_in),
        .extended_control_mode(u_ocsr_link_if.extended_control_mode),
        .data_clock_phase_select(u_ocsr_link_if.data_clock_phase_select),
        .demux_mode(u_ocsr_link_if.demux_mode),
        .first_channel_out_clock(u_ocsr_link_if.first_channel_out_clock),
        .second_channel_out_clock(u_ocsr_link_if.second_channel_out_clock), .realigned_r(realigned_r));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 99);
        if (i >= 99) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_re(input int n);
        int i;
        for (i = 0; i < 400 && n_re <= n; i++) @(posedge hclk);
        if (i == 400) begin
            n_errors++;
            stop_test();
        end
        repeat (60) @(posedge hclk);
    endtask
    // read data checker and realign latency tracker
    always @(posedge hclk) begin
        cyc++;
        if (rd_dp) begin
            chk("rdata", hrdata & q[0][63:32], q[0][31:0]);
            chk("hresp", {31'h0, hresp}, 32'h0);
            void'(q.pop_front());
        end
        rd_dp <= hresetn && htrans[1] && !hwrite;
        if ($fell(u_ocsr_link_if.out_clock_reset_in)) t_rel = cyc;
        if (realigned_r === 1'b1) begin
            n_re++;
            lat[u_ocsr_link_if.data_clock_phase_select] = cyc - t_rel;
        end
    end
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        logic [31:0] v;
        int n;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_dp = 1'b0;
        void'($urandom(32'hE5FDD48C));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'(ocsr_pkg::REG_CTRL), 32'hFFFFFFFF, 32'h0);
        rd(32'(ocsr_pkg::REG_STAT), 32'h3, 32'h0);
        bus(1'b1, 32'h10, $urandom);
        rd(32'h10, 32'hFFFFFFFF, 32'h0);
        rd(32'(ocsr_pkg::REG_CTRL), 32'hFFFFFFFF, 32'h0);
        $display("test registers done");
        bus(1'b1, 32'(ocsr_pkg::REG_CTRL), 32'h1);
        repeat (150) @(posedge hclk);
        chk("realign count", 32'(n_re), 32'h0);
        $display("test disabled mode done");
        for (int k = 0; k < 4; k++) begin
            v = {28'h0, k[1], 1'b1, k[0], 1'b1};
            n = n_re;
            repeat ($urandom_range(0, 7)) @(posedge hclk);
            bus(1'b1, 32'(ocsr_pkg::REG_CTRL), v);
            wait_re(n);
            rd(32'(ocsr_pkg::REG_STAT), 32'h3, 32'h2);
            rd(32'(ocsr_pkg::REG_CTRL), 32'hF, v & 32'hE);
            $display("test mode %0d done", k);
        end
        chk("phase delay", 32'(lat[0] - lat[1]), 32'(ocsr_pkg::REALIGN_CYC_0 - ocsr_pkg::REALIGN_CYC_90));
        stop_test();
    end
endmodule

// ===== verilog/ocsr_ctrl.sv
`timescale 1ns/1ps
module ocsr_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    ocsr_link_if.ctrl link
);
    typedef enum logic [1:0] {OCSR_IDLE, OCSR_PULSE, OCSR_GAP} ocsr_seq_e;
    ocsr_seq_e seq_r;
    logic ph_r, ecm_r, demux_r, go_r, rst_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [7:0] cnt_r;
    logic [7:0] pulses_r;
    logic pair_left_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= hsel & hready & htrans[1] & hwrite;
            if (hsel & hready & htrans[1]) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // throwaway pulse then synchronising pulse on each go that arrives while the sequencer is in OCSR_IDLE
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r <= 1'b0;
            ecm_r <= 1'b0;
            demux_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            go_r <= 1'b0;
            if (wr_pend_r && addr_r == ocsr_pkg::REG_CTRL) begin
                go_r <= hwdata[ocsr_pkg::CTRL_GO_BIT];
                ph_r <= hwdata[ocsr_pkg::CTRL_PHASE_BIT];
                ecm_r <= hwdata[ocsr_pkg::CTRL_ECM_BIT];
                demux_r <= hwdata[ocsr_pkg::CTRL_DEMUX_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_r <= OCSR_IDLE;
            rst_r <= 1'b0;
            cnt_r <= 8'h00;
            pair_left_r <= 1'b0;
            pulses_r <= 8'h00;
        end else begin
            unique case (seq_r)
                OCSR_IDLE: begin
                    if (go_r) begin
                        seq_r <= OCSR_PULSE;
                        rst_r <= 1'b1;
                        pair_left_r <= 1'b1;
                        cnt_r <= 8'(ocsr_pkg::MIN_PULSE_CYC + 3);
                    end
                end
                OCSR_PULSE: begin
                    if (cnt_r == 8'h01) begin
                        seq_r <= OCSR_GAP;
                        rst_r <= 1'b0;
                        pulses_r <= pulses_r + 8'h01;
                        cnt_r <= 8'(ocsr_pkg::REALIGN_CYC_0 + ocsr_pkg::RESTART_DLY_CYC + 8);
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                OCSR_GAP: begin
                    if (cnt_r != 8'h01) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (pair_left_r) begin
                        pair_left_r <= 1'b0;
                        seq_r <= OCSR_PULSE;
                        rst_r <= 1'b1;
                        cnt_r <= 8'(ocsr_pkg::MIN_PULSE_CYC + 3);
                    end else begin
                        seq_r <= OCSR_IDLE;
                    end
                end
                default: seq_r <= OCSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel & hready & htrans[1] & ~hwrite) begin
            hrdata <= 32'h0;
            if (haddr[7:0] == ocsr_pkg::REG_CTRL) begin
                hrdata[ocsr_pkg::CTRL_PHASE_BIT] <= ph_r;
                hrdata[ocsr_pkg::CTRL_ECM_BIT] <= ecm_r;
                hrdata[ocsr_pkg::CTRL_DEMUX_BIT] <= demux_r;
            end else if (haddr[7:0] == ocsr_pkg::REG_STAT) begin
                hrdata[ocsr_pkg::STAT_BUSY_BIT] <= (seq_r != OCSR_IDLE) | go_r;
                hrdata[ocsr_pkg::STAT_SYNCED_BIT] <= (pulses_r > 8'h01);
                hrdata[ocsr_pkg::STAT_CNT_LSB +: 8] <= pulses_r;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.out_clock_reset_in = rst_r;
    assign link.extended_control_mode = ecm_r;
    assign link.data_clock_phase_select = ph_r;
    assign link.demux_mode = demux_r;
endmodule

// ===== verilog/ocsr_device.sv
`timescale 1ns/1ps
// How it works
// - reset function only in extended control mode
// - both channel clocks share one source
// - release captured on rising sampling edge
// - demux: clock held high during reset
// - non-demux may glitch during reset
// - 90 degree mode realigns four cycles later
// - 0 degree mode realigns five cycles later
// - constant restart delay after realign edge
// - every pulse, the first included, recovers to the fixed phase
// - controller repeats pulse pair after power-up
// - followers need identical phase settings
// - demux clock is quarter rate, reset fixes phase
module ocsr_device (
    input wire logic hclk,
    input wire logic hresetn,
    ocsr_link_if.device link,
    output logic realigned_r
);
    typedef enum logic [1:0] {OCSR_RUN, OCSR_HOLD, OCSR_WAIT, OCSR_RESTART} ocsr_state_e;
    ocsr_state_e state_r;
    logic [2:0] rst_sync_r;
    logic [3:0] cnt_r;
    logic [1:0] phase_r;
    logic clk_r;
    logic seen_pulse_r;
    logic rst_lvl;
    logic rst_now;

    // three-stage input synchroniser, a level counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_sync_r <= 3'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[1:0], link.out_clock_reset_in};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_now <= 1'b0;
        end else if (rst_sync_r[1] == rst_sync_r[2]) begin
            rst_now <= rst_sync_r[2];
        end
    end

    assign rst_lvl = rst_now & link.extended_control_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= OCSR_RUN;
            cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                OCSR_RUN: begin
                    if (rst_lvl) begin
                        state_r <= OCSR_HOLD;
                    end
                end
                OCSR_HOLD: begin
                    if (!rst_lvl) begin
                        state_r <= OCSR_WAIT;
                        cnt_r <= link.data_clock_phase_select ? 4'(ocsr_pkg::REALIGN_CYC_90)
                                                              : 4'(ocsr_pkg::REALIGN_CYC_0);
                    end
                end
                OCSR_WAIT: begin
                    if (rst_lvl) begin
                        state_r <= OCSR_HOLD;
                    end else if (cnt_r == 4'h1) begin
                        state_r <= OCSR_RESTART;
                        cnt_r <= 4'(ocsr_pkg::RESTART_DLY_CYC);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                OCSR_RESTART: begin
                    if (rst_lvl) begin
                        state_r <= OCSR_HOLD;
                    end else if (cnt_r == 4'h1) begin
                        state_r <= OCSR_RUN;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
            endcase
        end
    end

    // seen_pulse_r is set in OCSR_HOLD, so every pulse, the first included, restarts from the fixed phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_pulse_r <= 1'b0;
        end else if (state_r == OCSR_HOLD) begin
            seen_pulse_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= 2'h0;
            clk_r <= 1'b1;
            realigned_r <= 1'b0;
        end else begin
            realigned_r <= 1'b0;
            if (state_r == OCSR_RUN) begin
                phase_r <= phase_r + 2'h1;
                clk_r <= link.demux_mode ? ~phase_r[1] : ~clk_r;
            end else if (state_r == OCSR_RESTART && cnt_r == 4'h1) begin
                phase_r <= seen_pulse_r ? ocsr_pkg::DEMUX_PHASE_RST[1:0] : phase_r;
                realigned_r <= 1'b1;
                clk_r <= 1'b1;
            end else if (link.demux_mode) begin
                clk_r <= 1'b1;
            end else begin
                clk_r <= 1'b0;
            end
        end
    end

    assign link.first_channel_out_clock = clk_r;
    assign link.second_channel_out_clock = clk_r;
endmodule

// ===== verilog/ocsr_link_if.sv
`timescale 1ns/1ps
interface ocsr_link_if;
    logic out_clock_reset_in;
    logic extended_control_mode;
    logic data_clock_phase_select;
    logic demux_mode;
    logic first_channel_out_clock;
    logic second_channel_out_clock;
    modport device (
        input out_clock_reset_in,
        input extended_control_mode,
        input data_clock_phase_select,
        input demux_mode,
        output first_channel_out_clock,
        output second_channel_out_clock
    );
    modport ctrl (
        output out_clock_reset_in,
        output extended_control_mode,
        output data_clock_phase_select,
        output demux_mode,
        input first_channel_out_clock,
        input second_channel_out_clock
    );
endinterface

// ===== verilog/ocsr_pkg.sv
package ocsr_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // realign delays in sampling clock cycles after first edge following release
    localparam int REALIGN_CYC_90 = 4;
    localparam int REALIGN_CYC_0 = 5;
    localparam int RESTART_DLY_CYC = 2;
    localparam int MIN_PULSE_NS = 40;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEMUX_DIV = 4;
    localparam logic [3:0] DEMUX_PHASE_RST = 4'h0;
    // controller register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_PHASE_BIT = 1;
    localparam int CTRL_ECM_BIT = 2;
    localparam int CTRL_DEMUX_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SYNCED_BIT = 1;
    localparam int STAT_CNT_LSB = 8;
endpackage
